/* File: rtl/dgc_playback_ctrl.sv */
// playback channel control registers, gain, mute and compressor path
`timescale 1ns/100ps
module dgc_playback_ctrl import dgc_pkg::*; #(
  parameter int SAMPLE_WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register access
  input wire dgc_reg_req_t regReq,
  output logic [7:0] regRdata_q,
  output logic regRdValid_q,
  // audio samples in
  input wire logic sampleTick,
  input wire logic signed [SAMPLE_WIDTH-1:0] leftIn,
  input wire logic signed [SAMPLE_WIDTH-1:0] rightIn,
  // audio sample out
  output logic signed [SAMPLE_WIDTH-1:0] sampleOut_q,
  output logic sampleValid_q,
  // status
  output logic dacPowered,
  output logic signed [8:0] rampGain,
  output logic [5:0] cmpReduction
);

  localparam int W = SAMPLE_WIDTH;
  localparam logic signed [W-1:0] FULL_SCALE = {1'b0, {(W-1){1'b1}}};

  // scales a sample by a gain in half-decibel units
  function automatic logic signed [W-1:0] applyGain(
    input logic signed [W-1:0] s,
    input logic signed [9:0] g
  );
    logic signed [10:0] uS;
    logic [9:0] u;
    logic [4:0] idx;
    logic [3:0] r;
    logic signed [63:0] prod;
    logic signed [63:0] shifted;
    uS = {g[9], g} + GAIN_OFFSET;
    u = uS[9:0];
    idx = 5'(u / STEPS_PER_OCTAVE);
    r = 4'(u % STEPS_PER_OCTAVE);
    prod = $signed({{(64-W){s[W-1]}}, s}) * $signed({48'h0, MANT_TABLE[r]});
    shifted = (prod <<< idx) >>> UNITY_SHIFT;
    if (uS[10]) begin
      applyGain = '0;
    end else if (shifted[63] && !(&shifted[62:W-1])) begin
      applyGain = {1'b1, {(W-1){1'b0}}};
    end else if (!shifted[63] && (|shifted[62:W-1])) begin
      applyGain = FULL_SCALE;
    end else begin
      applyGain = shifted[W-1:0];
    end
  endfunction : applyGain

  // register state
  dgc_path_setup_t pathSetup_q;
  dgc_path_setup_t pathSetup_d;
  dgc_mute_t mute_q;
  dgc_mute_t mute_d;
  logic [7:0] gain_q;
  logic [7:0] gain_d;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  dgc_cmp_ctrl_t cmpCtrl_q;
  dgc_cmp_ctrl_t cmpCtrl_d;
  logic [7:0] regRdata_d;
  logic regRdValid_d;

  always_comb begin
    pathSetup_d = pathSetup_q;
    mute_d = mute_q;
    gain_d = gain_q;
    gap_d = gap_q;
    cmpCtrl_d = cmpCtrl_q;
    regRdValid_d = regReq.read;
    regRdata_d = regRdata_q;
    if (regReq.write) begin
      unique case (regReq.addr)
        ADDR_PATH_SETUP: pathSetup_d = regReq.wdata;
        ADDR_MUTE: mute_d = regReq.wdata;
        ADDR_GAIN: gain_d = regReq.wdata;
        ADDR_GAP: gap_d = regReq.wdata;
        ADDR_CMP_CTRL: cmpCtrl_d = regReq.wdata;
        default: ;
      endcase
    end
    if (regReq.read) begin
      unique case (regReq.addr)
        ADDR_PATH_SETUP: regRdata_d = pathSetup_q;
        ADDR_MUTE: regRdata_d = mute_q;
        ADDR_GAIN: regRdata_d = gain_q;
        ADDR_GAP: regRdata_d = gap_q;
        ADDR_CMP_CTRL: regRdata_d = cmpCtrl_q;
        default: regRdata_d = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pathSetup_q <= RST_PATH_SETUP;
      mute_q <= RST_MUTE;
      gain_q <= RST_GAIN;
      gap_q <= RST_GAP;
      cmpCtrl_q <= RST_CMP_CTRL;
      regRdata_q <= READ_UNMAPPED;
      regRdValid_q <= 1'b0;
    end else begin
      pathSetup_q <= pathSetup_d;
      mute_q <= mute_d;
      gain_q <= gain_d;
      gap_q <= gap_d;
      cmpCtrl_q <= cmpCtrl_d;
      regRdata_q <= regRdata_d;
      regRdValid_q <= regRdValid_d;
    end
  end

  // volume ramp
  logic signed [8:0] rampTarget;
  logic rampAtFloor;

  assign rampTarget = mute_q.mute ? GAIN_FLOOR : {gain_q[7], gain_q};

  dgc_volume_ramp u_ramp (
    .clock(clock),
    .arst_n(arst_n),
    .sampleTick(sampleTick),
    .stepMode(pathSetup_q.softStep),
    .target(rampTarget),
    .current(rampGain),
    .atFloor(rampAtFloor)
  );

  // source select and level detection
  logic signed [W:0] lrSum;
  logic signed [W-1:0] srcSample;
  logic signed [W-1:0] preCmp;
  logic [W-1:0] level;
  logic [W-1:0] threshLevel;
  logic [W-1:0] releaseLevel;
  logic signed [9:0] rampGainWide;
  logic signed [9:0] thrHalf;
  logic signed [9:0] hystHalf;
  logic levelOver;
  logic levelBelow;

  assign lrSum = {leftIn[W-1], leftIn} + {rightIn[W-1], rightIn};

  always_comb begin
    unique case (pathSetup_q.source)
      SRC_OFF: srcSample = '0;
      SRC_LEFT: srcSample = leftIn;
      SRC_RIGHT: srcSample = rightIn;
      SRC_AVERAGE: srcSample = lrSum[W:1];
    endcase
  end

  assign rampGainWide = {rampGain[8], rampGain};
  assign preCmp = applyGain(srcSample, rampGainWide);
  assign level = preCmp[W-1] ? W'(-preCmp) : W'(preCmp);

  assign thrHalf = 10'h000 - THRESH_STEP_HALF_DB
                 - THRESH_STEP_HALF_DB * {7'h00, cmpCtrl_q.threshold};
  assign hystHalf = {7'h00, cmpCtrl_q.hysteresis, 1'b0};
  assign threshLevel = W'(applyGain(FULL_SCALE, thrHalf));
  assign releaseLevel = W'(applyGain(FULL_SCALE, thrHalf - hystHalf));
  assign levelOver = (level > threshLevel);
  assign levelBelow = (level < releaseLevel);

  // compressor gain reduction
  dgc_cmp_state_t cmpState_q;
  dgc_cmp_state_t cmpState_d;
  logic [5:0] reduction_q;
  logic [5:0] reduction_d;

  always_comb begin
    cmpState_d = cmpState_q;
    reduction_d = reduction_q;
    if (!cmpCtrl_q.enable) begin
      cmpState_d = CMP_IDLE;
      reduction_d = 6'h00;
    end else if (sampleTick) begin
      unique case (cmpState_q)
        CMP_IDLE: begin
          if (levelOver) begin
            cmpState_d = CMP_ENGAGED;
            reduction_d = reduction_q + 6'h01;
          end
        end
        CMP_ENGAGED: begin
          if (levelOver) begin
            if (reduction_q < CMP_MAX_REDUCTION) begin
              reduction_d = reduction_q + 6'h01;
            end
          end else if (levelBelow) begin
            if (reduction_q != 6'h00) begin
              reduction_d = reduction_q - 6'h01;
            end else begin
              cmpState_d = CMP_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmpState_q <= CMP_IDLE;
      reduction_q <= 6'h00;
    end else begin
      cmpState_q <= cmpState_d;
      reduction_q <= reduction_d;
    end
  end

  assign cmpReduction = reduction_q;

  // output sample
  logic signed [W-1:0] sampleOut_d;
  logic sampleValid_d;
  logic signed [9:0] outGain;

  assign outGain = rampGainWide - {4'h0, reduction_q};

  always_comb begin
    sampleOut_d = sampleOut_q;
    sampleValid_d = sampleTick;
    if (sampleTick) begin
      if (!pathSetup_q.power || rampAtFloor) begin
        sampleOut_d = '0;
      end else begin
        sampleOut_d = applyGain(srcSample, outGain);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sampleOut_q <= '0;
      sampleValid_q <= 1'b0;
    end else begin
      sampleOut_q <= sampleOut_d;
      sampleValid_q <= sampleValid_d;
    end
  end

  assign dacPowered = pathSetup_q.power;

  a_power_off_quiet:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && !pathSetup_q.power) |=> (sampleOut_q == '0))
    else $error("output not silent while powered down");

  a_power_bit_write:
    assert property (@(posedge clock) disable iff (!arst_n)
      (regReq.write && regReq.addr == ADDR_PATH_SETUP)
      |=> (pathSetup_q == $past(regReq.wdata) &&
           dacPowered == $past(regReq.wdata[7])))
    else $error("power bit did not follow the write");

  a_source_off_zero:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && pathSetup_q.source == SRC_OFF) |=> (sampleOut_q == '0))
    else $error("output not silent with source off");

  a_left_unity_pass:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && pathSetup_q.power && pathSetup_q.source == SRC_LEFT &&
       rampGain == 9'h000 && reduction_q == 6'h00)
      |=> (sampleOut_q == $past(leftIn)))
    else $error("left sample not passed at unity gain");

  a_right_unity_pass:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && pathSetup_q.power && pathSetup_q.source == SRC_RIGHT &&
       rampGain == 9'h000 && reduction_q == 6'h00)
      |=> (sampleOut_q == $past(rightIn)))
    else $error("right sample not passed at unity gain");

  a_mute_floor_quiet:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && mute_q.mute && rampGain == GAIN_FLOOR)
      |=> (sampleOut_q == '0))
    else $error("output not silent while muted");

  a_cmp_disabled_clear:
    assert property (@(posedge clock) disable iff (!arst_n)
      !cmpCtrl_q.enable |=> (reduction_q == 6'h00))
    else $error("reduction present while compressor disabled");

  a_cmp_attack_step:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && cmpCtrl_q.enable && levelOver &&
       reduction_q < CMP_MAX_REDUCTION)
      |=> (reduction_q == $past(reduction_q) + 6'h01))
    else $error("compressor did not attack above threshold");

  a_cmp_hold_band:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && cmpCtrl_q.enable && cmpState_q == CMP_ENGAGED &&
       !levelOver && !levelBelow) |=> $stable(reduction_q))
    else $error("reduction moved inside hysteresis band");

endmodule : dgc_playback_ctrl

/* File: rtl/dgc_pkg.sv */
// constants, register layouts and types for the playback gain and mute block
package dgc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PATH_SETUP = 8'h3f;
  localparam logic [7:0] ADDR_MUTE = 8'h40;
  localparam logic [7:0] ADDR_GAIN = 8'h41;
  localparam logic [7:0] ADDR_GAP = 8'h42;
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h44;

  // reset values
  localparam logic [7:0] RST_PATH_SETUP = 8'h14;
  localparam logic [7:0] RST_MUTE = 8'h0c;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_GAP = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL = 8'h0f;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // source select codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_LEFT = 2'h1;
  localparam logic [1:0] SRC_RIGHT = 2'h2;
  localparam logic [1:0] SRC_AVERAGE = 2'h3;

  // soft-step codes
  localparam logic [1:0] STEP_EVERY = 2'h0;
  localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
  localparam logic [1:0] STEP_NONE = 2'h2;

  // gain arithmetic, all gains in half-decibel units
  localparam logic signed [8:0] GAIN_FLOOR = 9'h180;
  localparam logic signed [10:0] GAIN_OFFSET = 11'h0b4;
  localparam logic [9:0] STEPS_PER_OCTAVE = 10'h00c;
  localparam int UNITY_SHIFT = 29;
  localparam logic [15:0] MANT_TABLE [12] = '{
    16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5559,
    16'h5a67, 16'h5fc3, 16'h6570, 16'h6b73, 16'h71d1, 16'h7890
  };

  // compressor settings
  localparam logic [9:0] THRESH_STEP_HALF_DB = 10'h006;
  localparam logic [5:0] CMP_MAX_REDUCTION = 6'h30;

  typedef struct packed {
    logic power;
    logic rsvdHi;
    logic [1:0] source;
    logic [1:0] rsvdMid;
    logic [1:0] softStep;
  } dgc_path_setup_t;

  typedef struct packed {
    logic [3:0] rsvdHi;
    logic mute;
    logic [2:0] rsvdLo;
  } dgc_mute_t;

  typedef struct packed {
    logic rsvdTop;
    logic enable;
    logic rsvdMid;
    logic [2:0] threshold;
    logic [1:0] hysteresis;
  } dgc_cmp_ctrl_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dgc_reg_req_t;

  typedef enum logic {CMP_IDLE, CMP_ENGAGED} dgc_cmp_state_t;

endpackage : dgc_pkg

/* File: rtl/dgc_volume_ramp.sv */
// soft-stepping volume ramp toward a target gain
`timescale 1ns/100ps
module dgc_volume_ramp import dgc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // sample timing and control
  input wire logic sampleTick,
  input wire logic [1:0] stepMode,
  input wire logic signed [8:0] target,
  // ramp state
  output logic signed [8:0] current,
  output logic atFloor
);

  logic signed [8:0] current_q;
  logic signed [8:0] current_d;
  logic phase_q;
  logic phase_d;

  always_comb begin
    current_d = current_q;
    phase_d = phase_q;
    if (sampleTick) begin
      if (stepMode == STEP_EVERY ||
          (stepMode == STEP_EVERY_TWO && phase_q)) begin
        if (current_q < target) begin
          current_d = current_q + 9'h001;
        end else if (current_q > target) begin
          current_d = current_q - 9'h001;
        end
      end else if (stepMode != STEP_EVERY_TWO) begin
        current_d = target;
      end
      phase_d = (stepMode == STEP_EVERY_TWO) ? !phase_q : 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      current_q <= GAIN_FLOOR;
      phase_q <= 1'b0;
    end else begin
      current_q <= current_d;
      phase_q <= phase_d;
    end
  end

  assign current = current_q;
  assign atFloor = (current_q == GAIN_FLOOR);

  a_ramp_single_step:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && stepMode == STEP_EVERY && current_q != target)
      |=> (current_q - $past(current_q) == 9'h001 ||
           $past(current_q) - current_q == 9'h001))
    else $error("ramp did not move by one step");

  a_ramp_jump_disabled:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && stepMode == STEP_NONE)
      |=> (current_q == $past(target)))
    else $error("ramp did not jump with stepping disabled");

  a_ramp_half_rate:
    assert property (@(posedge clock) disable iff (!arst_n)
      (sampleTick && stepMode == STEP_EVERY_TWO && !phase_q)
      |=> $stable(current_q))
    else $error("ramp stepped on the skipped period");

endmodule : dgc_volume_ramp

/* File: dv/dgc_playback_ctrl_tb_top.sv */
// self-checking bench for the playback control register block
`timescale 1ns/100ps
module dgc_playback_ctrl_tb_top import dgc_pkg::*;;
  localparam logic [15:0] SRC_EXP [4] = '{16'h0000, 16'h03e8, 16'hf447,
    16'hfc17};
  localparam logic [8:0] STEP_EXP [4] = '{9'h002, 9'h001, 9'h001, 9'h000};
  logic clock;
  logic arst_n = 1'b0;
  dgc_reg_req_t regReq = '0;
  logic sampleTick = 1'b0;
  logic signed [15:0] leftIn = '0;
  logic signed [15:0] rightIn = '0;
  logic [7:0] regRdata_q;
  logic regRdValid_q;
  logic signed [15:0] sampleOut_q;
  logic sampleValid_q;
  logic dacPowered;
  logic signed [8:0] rampGain;
  logic [5:0] cmpReduction;
  int n_mismatch = 0;
  int checks = 0;

  dgc_playback_ctrl #(.SAMPLE_WIDTH(16)) dgc_playback_ctrl_i (
    .clock(clock), .arst_n(arst_n), .regReq(regReq),
    .regRdata_q(regRdata_q), .regRdValid_q(regRdValid_q),
    .sampleTick(sampleTick), .leftIn(leftIn), .rightIn(rightIn),
    .sampleOut_q(sampleOut_q), .sampleValid_q(sampleValid_q),
    .dacPowered(dacPowered), .rampGain(rampGain),
    .cmpReduction(cmpReduction)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic cmp(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    regReq = '0;
    // idle cycle so the next call never re-drives the strobe at once
    @(negedge clock);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a,
      input logic [7:0] e);
    regReq = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    regReq = '0;
    cmp("read valid", 16'h0001, {15'h0000, regRdValid_q});
    cmp(what, {8'h00, e}, {8'h00, regRdata_q});
    @(negedge clock);
  endtask : rd

  // one sample period; output settles one cycle after the tick
  task automatic tick(input logic [15:0] l, input logic [15:0] r);
    leftIn = l;
    rightIn = r;
    sampleTick = 1'b1;
    @(negedge clock);
    sampleTick = 1'b0;
    cmp("sample valid", 16'h0001, {15'h0000, sampleValid_q});
    @(negedge clock);
    cmp("sample valid low", 16'h0000, {15'h0000, sampleValid_q});
  endtask : tick

  task automatic out(input logic [15:0] e);
    cmp("sample out", e, sampleOut_q);
  endtask : out

  task automatic ramp(input logic [8:0] e);
    cmp("ramp gain", {7'h00, e}, {7'h00, rampGain});
  endtask : ramp

  task automatic red(input logic [5:0] e);
    cmp("reduction", {10'h000, e}, {10'h000, cmpReduction});
  endtask : red

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    rd("path setup", ADDR_PATH_SETUP, 8'h14);
    rd("mute", ADDR_MUTE, 8'h0c);
    rd("gain", ADDR_GAIN, 8'h00);
    rd("gap", ADDR_GAP, 8'h00);
    rd("compressor", ADDR_CMP_CTRL, 8'h0f);
    wr(8'h43, 8'h5a);
    rd("unmapped", 8'h43, 8'h00);
    cmp("powered", 16'h0000, {15'h0000, dacPowered});
    ramp(9'h180);
    red(6'h00);
    $display("test reset done");
    wr(ADDR_GAP, 8'h00);
    wr(ADDR_PATH_SETUP, 8'h96);
    cmp("powered", 16'h0001, {15'h0000, dacPowered});
    wr(ADDR_MUTE, 8'h04);
    tick(16'h03e8, 16'hf447);
    out(16'h0000);
    ramp(9'h000);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_PATH_SETUP, {2'b10, s[1:0], 4'b0110});
      tick(16'h03e8, 16'hf447);
      out(SRC_EXP[s]);
    end
    wr(ADDR_PATH_SETUP, 8'h16);
    cmp("powered", 16'h0000, {15'h0000, dacPowered});
    tick(16'h03e8, 16'h0000);
    out(16'h0000);
    wr(ADDR_PATH_SETUP, 8'h96);
    $display("test path done");
    wr(ADDR_GAIN, 8'h0c);
    tick(16'h03e8, 16'h0000);
    out(16'h03e8);
    tick(16'h03e8, 16'h0000);
    out(16'h07d0);
    tick(16'h4e20, 16'h0000);
    out(16'h7fff);
    wr(ADDR_GAIN, 8'h30);
    tick(16'h03e8, 16'h0000);
    tick(16'h03e8, 16'h0000);
    out(16'h3e80);
    wr(ADDR_GAIN, 8'h81);
    rd("gain", ADDR_GAIN, 8'h81);
    tick(16'h0000, 16'h0000);
    ramp(9'h181);
    wr(ADDR_GAIN, 8'h00);
    tick(16'h0000, 16'h0000);
    wr(ADDR_MUTE, 8'h0c);
    tick(16'h03e8, 16'h0000);
    ramp(9'h180);
    tick(16'h03e8, 16'h0000);
    out(16'h0000);
    wr(ADDR_MUTE, 8'h04);
    tick(16'h03e8, 16'h0000);
    $display("test gain done");
    wr(ADDR_PATH_SETUP, 8'h94);
    wr(ADDR_GAIN, 8'h02);
    tick(16'h03e8, 16'h0000);
    ramp(9'h001);
    tick(16'h03e8, 16'h0000);
    ramp(9'h002);
    tick(16'h03e8, 16'h0000);
    ramp(9'h002);
    wr(ADDR_PATH_SETUP, 8'h95);
    wr(ADDR_GAIN, 8'h00);
    for (int i = 0; i < 4; i++) begin
      tick(16'h03e8, 16'h0000);
      ramp(STEP_EXP[i]);
    end
    $display("test step done");
    wr(ADDR_PATH_SETUP, 8'h96);
    wr(ADDR_CMP_CTRL, 8'h1f);
    tick(16'h0fa0, 16'h0000);
    tick(16'h0fa0, 16'h0000);
    red(6'h00);
    wr(ADDR_CMP_CTRL, 8'h5f);
    tick(16'h0fa0, 16'h0000);
    red(6'h01);
    tick(16'h0fa0, 16'h0000);
    red(6'h02);
    tick(16'h0708, 16'h0000);
    red(6'h02);
    tick(16'h01f4, 16'h0000);
    red(6'h01);
    wr(ADDR_CMP_CTRL, 8'h43);
    tick(16'h0fa0, 16'h0000);
    red(6'h00);
    wr(ADDR_CMP_CTRL, 8'h5f);
    tick(16'h0fa0, 16'h0000);
    red(6'h01);
    wr(ADDR_CMP_CTRL, 8'h1f);
    @(negedge clock);
    red(6'h00);
    $display("test compressor done");
    summarize();
  end
endmodule : dgc_playback_ctrl_tb_top
